// [ckg_defs.svh]
// Constants for the clock generator serial control register bank.
// Assumes inclusion by its bare name from the package and the design module.
`ifndef CKG_DEFS_SVH
`define CKG_DEFS_SVH

// Serial address, upper seven bits of the 8-bit pattern 8'hD2
`define CKG_DEV_ADDR7      7'h69

// Command code fields
`define CKG_CMD_BYTE_BIT   7
`define CKG_CMD_CS_HI      6
`define CKG_CMD_CS_LO      5
`define CKG_CMD_CS_VAL     2'h0
`define CKG_CMD_OFF_HI     4

// Register offsets
`define CKG_OFF_DIFF_EN    5'h00
`define CKG_OFF_MISC_EN    5'h01
`define CKG_OFF_SPREAD     5'h02
`define CKG_OFF_STOP_PD    5'h03
`define CKG_OFF_REQ0       5'h04
`define CKG_OFF_REQ1       5'h05
`define CKG_OFF_TEST       5'h06
`define CKG_OFF_IDENT      5'h07

// Reset values (reserved bits included)
`define CKG_RST_DIFF_EN    8'hFF
`define CKG_RST_MISC_EN    8'hFF
`define CKG_RST_SPREAD     8'hEB
`define CKG_RST_STOP_PD    8'hAF
`define CKG_RST_REQ0       8'h03
`define CKG_RST_REQ1       8'h00
`define CKG_RST_TEST       3'h0

// Writable bits of each byte; reserved bits hold their reset value
`define CKG_WM_DIFF_EN     8'hFF
`define CKG_WM_MISC_EN     8'hFF
`define CKG_WM_SPREAD      8'hE4
`define CKG_WM_STOP_PD     8'hFE
`define CKG_WM_REQ0        8'hFC
`define CKG_WM_REQ1        8'hFC

// Test byte: writable bits 7..5, bit 4 reserved low, bits 3..0 straps
`define CKG_TEST_HI        7
`define CKG_TEST_LO        5

`endif

// [ckg_master_model.sv]
// Serial bus master model: start, stop, byte send and byte receive.
// Assumes the bench resolves the pulled-up data wire and feeds it back on i_sda.
`timescale 1ns/1ps
`default_nettype none

module ckg_master_model (
	// Clock and resolved data wire
	input  wire logic i_clk,
	input  wire logic i_sda,
	// Serial pins driven by the master, open drain data
	output var  logic o_scl,
	output var  logic o_sda
);
	// Link idles high, as the pull-ups leave it
	initial
	begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end

	// Four clocks a phase, twice the slave's minimum, so no edge is missed
	task automatic hold();
		repeat (4) @(posedge i_clk);
	endtask

	// Start or repeated start; data rises while the clock is low, then falls while it is high
	task automatic start();
		o_sda <= 1'b1;
		hold();
		o_scl <= 1'b1;
		hold();
		o_sda <= 1'b0;
		hold();
		o_scl <= 1'b0;
		hold();
	endtask

	task automatic stop();
		o_sda <= 1'b0;
		hold();
		o_scl <= 1'b1;
		hold();
		o_sda <= 1'b1;
		hold();
	endtask

	// One bit; the wire is sampled at the end of the high phase
	task automatic xfer(input logic b, output logic r);
		o_sda <= b;
		hold();
		o_scl <= 1'b1;
		hold();
		r = i_sda;
		o_scl <= 1'b0;
		hold();
	endtask

	// Byte out MSB first, then the slave's acknowledge slot
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			xfer(d[i], r);
		xfer(1'b1, r);
		ack = ~r;
	endtask

	// Byte in, always closed by a not-acknowledge
	task automatic recv(output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			xfer(1'b1, d[i]);
		xfer(1'b1, r);
	endtask
endmodule
`default_nettype wire

// [ckg_pkg.sv]
// Types for the clock generator serial control register bank.
// Assumes ckg_defs.svh is on the include path.
`include "ckg_defs.svh"

package ckg_pkg;

	// Serial transfer phases
	typedef enum logic [3:0] {
		S_IDLE,
		S_ADDR,
		S_ADDR_ACK,
		S_CMD,
		S_CMD_ACK,
		S_WDATA,
		S_WDATA_ACK,
		S_RDATA,
		S_RACK,
		S_DONE
	} ckg_state_t;

	// Whole state of the block
	typedef struct packed {
		ckg_state_t      state;
		logic            scl_q;
		logic            sda_q;
		logic [2:0]      cnt;
		logic [7:0]      shift;
		logic            rw;
		logic [4:0]      offset;
		logic            oe;
		logic [5:0][7:0] cfg;
		logic [2:0]      test_ctl;
		logic [3:0]      strap;
		logic            strap_done;
	} ckg_regs_t;

endpackage

// [ckg_smbus_regs.sv]
// Serial-bus slave holding the control bytes of a multi-output clock generator.
// Assumes the serial clock and data levels arrive synchronous to i_sys_clk
// and are slow against it; the data wire is open drain, resolved outside.
//
// Function
// - Byte write: address+write, command, data; each byte acknowledged, then stop.
// - Byte read: repeated start, address with read bit, device acknowledges it.
// - Device sends one register byte; master answers not-acknowledge then stop.
// - Byte 0 holds differential output enables; zero means high impedance; reset ones.
// - Byte 1 holds reference, PCI, USB and CPU enables; all reset to one.
// - Byte 2 bit 7 picks spread depth, 0.35 or 0.50 percent; reset one.
// - Byte 2 bits 6 and 5 set USB and PCI drive strength; reset one.
// - Byte 2 bit 2 turns spread on; reset zero; bits 4,3,1,0 reserved.
// - Byte 3 bit 7 chooses driven or tri-state for request-stopped pairs.
// - Byte 3 bits 6 and 5 set power-down hold mode for CPU and reference.
// - Byte 3 bit 4 sets CPU-stop hold mode; reset zero.
// - Byte 3 bits 3..1 mark CPU pairs stoppable; reset one; bit 0 reserved.
// - Byte 4 bits 7..2 stoppable by request 0; reset zero; low bits one.
// - Byte 5 bits 7..2 stoppable by request 1; reset zero; low bits zero.
// - Byte 6 bit 6 enters test mode; bit 7 picks divided clock or tri-state.
// - Byte 6 bit 5 sets reference drive strength; reset zero; bit 4 reserved.
// - Byte 6 bits 3..0 return straps latched at power-good; read-only.
// - Command bit 7 selects byte transfer, bits 6:5 must be zero, 4:0 offset.
// - Device answers only to address bits 7..1 of 8'hD2; bit 0 picks read or write.
// - All control bytes take defaults at reset; the bus need never be used.
`timescale 1ns/1ps
`default_nettype none
`include "ckg_defs.svh"

module ckg_smbus_regs #(
	parameter logic [3:0] REV_CODE    = 4'hA, // Arbitrary value
	parameter logic [3:0] VENDOR_CODE = 4'h5  // Arbitrary value
) (
	// Clock and reset
	input  wire logic       i_sys_clk,
	input  wire logic       i_resetn,
	// Serial link, data pin as input, output and enable
	input  wire logic       i_scl,
	input  wire logic       i_sda_in,
	output wire logic       o_sda_out,
	output wire logic       o_sda_oe,
	// Strap pins and their latch strobe
	input  wire logic       i_power_good_strobe_n,
	input  wire logic       i_freq_strap_a,
	input  wire logic       i_freq_strap_b,
	input  wire logic       i_freq_strap_c,
	input  wire logic       i_table_sel_strap,
	// Control bytes to the clock core
	output wire logic [7:0] o_diff_ref_output_enables,
	output wire logic [7:0] o_misc_output_enables,
	output wire logic [7:0] o_spread_and_drive_control,
	output wire logic [7:0] o_stop_and_powerdown_modes,
	output wire logic [7:0] o_request0_stoppable_mask,
	output wire logic [7:0] o_request1_stoppable_mask,
	output wire logic [7:0] o_test_and_strap_status
);
	import ckg_pkg::*;

	// Reset image of the whole state
	localparam ckg_regs_t ST_RST = '{
		state:      S_IDLE,
		scl_q:      1'b1,
		sda_q:      1'b1,
		cnt:        3'h0,
		shift:      8'h00,
		rw:         1'b0,
		offset:     5'h00,
		oe:         1'b0,
		cfg:        {`CKG_RST_REQ1, `CKG_RST_REQ0, `CKG_RST_STOP_PD,
		             `CKG_RST_SPREAD, `CKG_RST_MISC_EN, `CKG_RST_DIFF_EN},
		test_ctl:   `CKG_RST_TEST,
		strap:      4'h0,
		strap_done: 1'b0
	};

	ckg_regs_t  st;
	ckg_regs_t  next_st;
	logic       scl_rise;
	logic       scl_fall;
	logic       bus_start;
	logic       bus_stop;
	logic [7:0] byte_in;
	logic [7:0] rd_val;
	logic       wr_fire;
	logic       cmd_ok;

	// Byte returned for a read offset; unmapped offsets read as zero
	function automatic logic [7:0] rd_byte(input ckg_regs_t s, input logic [4:0] off);
		logic [7:0] r;
		r = 8'h00;
		if (off < `CKG_OFF_TEST)
			r = s.cfg[off[2:0]];
		else if (off == `CKG_OFF_TEST)
			r = {s.test_ctl, 1'b0, s.strap};
		else if (off == `CKG_OFF_IDENT)
			r = {REV_CODE, VENDOR_CODE};
		return r;
	endfunction

	// Writable bit mask per configuration byte
	function automatic logic [7:0] wr_mask(input logic [2:0] idx);
		logic [7:0] m;
		m = 8'h00;
		if (idx == `CKG_OFF_DIFF_EN)
			m = `CKG_WM_DIFF_EN;
		else if (idx == `CKG_OFF_MISC_EN)
			m = `CKG_WM_MISC_EN;
		else if (idx == `CKG_OFF_SPREAD)
			m = `CKG_WM_SPREAD;
		else if (idx == `CKG_OFF_STOP_PD)
			m = `CKG_WM_STOP_PD;
		else if (idx == `CKG_OFF_REQ0)
			m = `CKG_WM_REQ0;
		else if (idx == `CKG_OFF_REQ1)
			m = `CKG_WM_REQ1;
		return m;
	endfunction

	// Next-state logic; start and stop override any phase so a stuck
	// transfer is always recoverable by the master
	always_comb
	begin
		next_st = st;
		scl_rise = i_scl & ~st.scl_q;
		scl_fall = ~i_scl & st.scl_q;
		bus_start = i_scl & st.scl_q & st.sda_q & ~i_sda_in;
		bus_stop = i_scl & st.scl_q & ~st.sda_q & i_sda_in;
		byte_in = {st.shift[6:0], i_sda_in};
		wr_fire = (st.state == S_WDATA) && scl_rise && (st.cnt == 3'h7);
		rd_val = rd_byte(st, st.offset);
		cmd_ok = byte_in[`CKG_CMD_BYTE_BIT]
			&& (byte_in[`CKG_CMD_CS_HI:`CKG_CMD_CS_LO] == `CKG_CMD_CS_VAL);
		next_st.scl_q = i_scl;
		next_st.sda_q = i_sda_in;

		// One-shot strap capture at the first low strobe sample
		if (!st.strap_done && !i_power_good_strobe_n)
		begin
			next_st.strap = {i_table_sel_strap, i_freq_strap_c,
				i_freq_strap_b, i_freq_strap_a};
			next_st.strap_done = 1'b1;
		end

		if (bus_start)
		begin
			next_st.state = S_ADDR;
			next_st.cnt = 3'h0;
			next_st.oe = 1'b0;
		end
		else if (bus_stop)
		begin
			next_st.state = S_IDLE;
			next_st.oe = 1'b0;
		end
		else
		begin
			case (st.state)
				S_ADDR, S_CMD, S_WDATA:
				begin
					if (scl_rise)
					begin
						next_st.shift = byte_in;
						next_st.cnt = st.cnt + 3'h1;
						if (st.cnt == 3'h7)
						begin
							if (st.state == S_ADDR)
							begin
								if (byte_in[7:1] == `CKG_DEV_ADDR7)
								begin
									next_st.rw = byte_in[0];
									next_st.state = S_ADDR_ACK;
								end
								else
									next_st.state = S_IDLE;
							end
							else if (st.state == S_CMD)
							begin
								next_st.offset = byte_in[`CKG_CMD_OFF_HI:0];
								next_st.state = cmd_ok ? S_CMD_ACK : S_IDLE;
							end
							else
							begin
								// Write commit; ident and unmapped offsets ignore it
								if (st.offset < `CKG_OFF_TEST)
									next_st.cfg[st.offset[2:0]] =
										(st.cfg[st.offset[2:0]] & ~wr_mask(st.offset[2:0]))
										| (byte_in & wr_mask(st.offset[2:0]));
								else if (st.offset == `CKG_OFF_TEST)
									next_st.test_ctl = byte_in[`CKG_TEST_HI:`CKG_TEST_LO];
								next_st.state = S_WDATA_ACK;
							end
						end
					end
				end
				S_ADDR_ACK, S_CMD_ACK, S_WDATA_ACK:
				begin
					// Pull low on the first fall; on the second release, or drive read bit 7
					if (scl_fall)
					begin
						next_st.cnt = 3'h0;
						if (!st.oe)
							next_st.oe = 1'b1;
						else if (st.state == S_ADDR_ACK && st.rw)
						begin
							next_st.shift = rd_val;
							next_st.oe = ~rd_val[7];
							next_st.state = S_RDATA;
						end
						else
						begin
							next_st.oe = 1'b0;
							if (st.state == S_ADDR_ACK)
								next_st.state = S_CMD;
							else if (st.state == S_CMD_ACK)
								next_st.state = S_WDATA;
							else
								next_st.state = S_DONE;
						end
					end
				end
				S_RDATA:
				begin
					if (scl_rise)
					begin
						next_st.cnt = st.cnt + 3'h1;
						if (st.cnt == 3'h7)
							next_st.state = S_RACK;
					end
					else if (scl_fall)
					begin
						next_st.shift = {st.shift[6:0], 1'b0};
						next_st.oe = ~st.shift[6];
					end
				end
				S_RACK:
				begin
					// Single byte only; the master's answer is not inspected
					if (scl_fall)
						next_st.oe = 1'b0;
					else if (scl_rise)
						next_st.state = S_DONE;
				end
				default:
				begin
					next_st.oe = 1'b0;
				end
			endcase
		end
	end

	// State register; reset restores every default
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			st <= ST_RST;
		else
			st <= next_st;
	end

	// Outputs straight from the state flops; o_sda_out tied low
	assign o_sda_out = 1'b0;
	assign o_sda_oe = st.oe;
	assign o_diff_ref_output_enables = st.cfg[`CKG_OFF_DIFF_EN];
	assign o_misc_output_enables = st.cfg[`CKG_OFF_MISC_EN];
	assign o_spread_and_drive_control = st.cfg[`CKG_OFF_SPREAD];
	assign o_stop_and_powerdown_modes = st.cfg[`CKG_OFF_STOP_PD];
	assign o_request0_stoppable_mask = st.cfg[`CKG_OFF_REQ0];
	assign o_request1_stoppable_mask = st.cfg[`CKG_OFF_REQ1];
	assign o_test_and_strap_status = {st.test_ctl, 1'b0, st.strap};

	// Checks on the serial sequence and the register contents
	a_addr_match_ack: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_ADDR && scl_rise && st.cnt == 3'h7 && !bus_start && !bus_stop
		&& byte_in[7:1] == `CKG_DEV_ADDR7) |=> (st.state == S_ADDR_ACK))
		else $error("matching address not acknowledged");

	a_addr_miss_idle: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_ADDR && scl_rise && st.cnt == 3'h7 && !bus_start && !bus_stop
		&& byte_in[7:1] != `CKG_DEV_ADDR7) |=> (st.state == S_IDLE && !st.oe))
		else $error("foreign address not ignored");

	a_cmd_check: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_CMD && scl_rise && st.cnt == 3'h7 && !bus_start && !bus_stop
		&& !cmd_ok) |=> (st.state == S_IDLE))
		else $error("block or foreign command acknowledged");

	a_write_commit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(wr_fire && st.offset == `CKG_OFF_MISC_EN && !bus_start && !bus_stop)
		|=> (o_misc_output_enables == $past(byte_in)) && (st.state == S_WDATA_ACK))
		else $error("byte write not stored");

	a_read_first_bit: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_ADDR_ACK && st.rw && st.oe && scl_fall && !bus_start && !bus_stop)
		|=> (st.state == S_RDATA) && (st.oe == ~$past(rd_val[7])))
		else $error("read data bit 7 wrong");

	a_rack_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_RACK && scl_fall && !bus_start && !bus_stop) |=> !st.oe)
		else $error("data line held during master answer");

	a_reserved_bits: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(o_spread_and_drive_control[4:0] & ~`CKG_WM_SPREAD) == (`CKG_RST_SPREAD & 8'h1B))
		else $error("reserved spread bits changed");

	a_strap_oneshot: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		st.strap_done |=> st.strap_done && $stable(o_test_and_strap_status[3:0]))
		else $error("strap values changed after capture");

	a_stop_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(bus_stop && !bus_start) |=> (st.state == S_IDLE) && !o_sda_oe)
		else $error("stop did not end the transfer");

	a_cmd_accept: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_CMD && scl_rise && st.cnt == 3'h7 && !bus_start && !bus_stop
		&& cmd_ok) |=> (st.state == S_CMD_ACK))
		else $error("byte command not acknowledged");

	a_wack_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_WDATA_ACK && st.oe && scl_fall && !bus_start && !bus_stop)
		|=> (st.state == S_DONE) && !st.oe)
		else $error("data acknowledge not released");

	a_ident_readonly: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(wr_fire && st.offset == `CKG_OFF_IDENT && !bus_start && !bus_stop)
		|=> $stable(st.cfg) && $stable(st.test_ctl))
		else $error("write to identification byte changed a register");

	a_test_write: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(wr_fire && st.offset == `CKG_OFF_TEST && !bus_start && !bus_stop)
		|=> (o_test_and_strap_status[7:5] == $past(byte_in[7:5]))
		&& !o_test_and_strap_status[4])
		else $error("test controls not stored");

	a_read_bit_next: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_RDATA && scl_fall && !bus_start && !bus_stop)
		|=> (st.oe == ~$past(st.shift[6])))
		else $error("read data bit not shifted out");

	a_rack_done: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(st.state == S_RACK && scl_rise && !bus_start && !bus_stop)
		|=> (st.state == S_DONE))
		else $error("read not closed after master answer");

endmodule
`default_nettype wire

// [ckg_smbus_regs_tb.sv]
// Self-checking bench for the clock generator control register bank.
// Assumes the master model drives the link and the data wire has a pull-up.
`timescale 1ns/1ps
`default_nettype none

module ckg_smbus_regs_tb;
	import ckg_pkg::*;
	logic            i_sys_clk = 1'b0;
	logic            i_resetn  = 1'b0;
	logic            pgood_n   = 1'b1;
	logic [3:0]      straps    = 4'h0;
	wire logic       scl;
	wire logic       m_sda;
	wire logic       sda_oe;
	wire logic       sda_out;
	wire logic [7:0] q [7];
	// Open drain wire: low when either party pulls, else the pull-up
	wire logic       sda = m_sda & ~(sda_oe & ~sda_out);
	int              num_errors = 0;
	int              checked    = 0;
	localparam logic [7:0] RST [6] = '{8'hFF, 8'hFF, 8'hEB, 8'hAF, 8'h03, 8'h00};
	localparam logic [7:0] WM  [6] = '{8'hFF, 8'hFF, 8'hE4, 8'hFE, 8'hFC, 8'hFC};

	// 125 MHz system clock
	always #4 i_sys_clk = ~i_sys_clk;

	ckg_smbus_regs #(
		.REV_CODE    (4'h3), // Arbitrary value
		.VENDOR_CODE (4'hC)  // Arbitrary value
	) u_ckg_smbus_regs (
		.i_sys_clk                  (i_sys_clk),
		.i_resetn                   (i_resetn),
		.i_scl                      (scl),
		.i_sda_in                   (sda),
		.o_sda_out                  (sda_out),
		.o_sda_oe                   (sda_oe),
		.i_power_good_strobe_n      (pgood_n),
		.i_freq_strap_a             (straps[0]),
		.i_freq_strap_b             (straps[1]),
		.i_freq_strap_c             (straps[2]),
		.i_table_sel_strap          (straps[3]),
		.o_diff_ref_output_enables  (q[0]),
		.o_misc_output_enables      (q[1]),
		.o_spread_and_drive_control (q[2]),
		.o_stop_and_powerdown_modes (q[3]),
		.o_request0_stoppable_mask  (q[4]),
		.o_request1_stoppable_mask  (q[5]),
		.o_test_and_strap_status    (q[6])
	);

	ckg_master_model u_ckg_master_model (
		.i_clk (i_sys_clk),
		.i_sda (sda),
		.o_scl (scl),
		.o_sda (m_sda)
	);

	task automatic give_verdict();
		$display("Errors %0d in %0d checks", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error t=%0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error t=%0t ack %b expected %b", $time, got, exp);
		end
	endtask

	// Byte write: address, command, data, each acknowledge checked
	task automatic wr(input logic [7:0] adr, cmd, dat, input logic exp);
		logic a;
		u_ckg_master_model.start();
		u_ckg_master_model.send(adr, a);
		chk1(a, adr == 8'hD2);
		u_ckg_master_model.send(cmd, a);
		chk1(a, exp);
		u_ckg_master_model.send(dat, a);
		chk1(a, exp);
		u_ckg_master_model.stop();
	endtask

	task automatic rd(input logic [7:0] cmd, output logic [7:0] d);
		logic a;
		u_ckg_master_model.start();
		u_ckg_master_model.send(8'hD2, a);
		u_ckg_master_model.send(cmd, a);
		u_ckg_master_model.start();
		u_ckg_master_model.send(8'hD3, a);
		chk1(a, 1'b1);
		u_ckg_master_model.recv(d);
		u_ckg_master_model.stop();
	endtask

	// All bytes at their defaults, straps not yet latched
	task automatic t_reset();
		for (int i = 0; i < 6; i++)
			chk8(q[i], RST[i]);
		chk8(q[6], 8'h00);
	endtask

	// Straps latch once; a later strobe or strap change is ignored
	task automatic t_straps();
		straps <= 4'hA;
		@(posedge i_sys_clk);
		pgood_n <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		straps <= 4'h5;
		pgood_n <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		pgood_n <= 1'b0;
		repeat (3) @(posedge i_sys_clk);
		chk8(q[6], 8'h0A);
	endtask

	// Two inverse patterns per byte; reserved bits must keep their defaults
	task automatic t_write_all();
		logic [7:0] d;
		logic [7:0] e;
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 6; i++)
			begin
				e = (RST[i] & ~WM[i]) | ((p == 0 ? 8'h5A : 8'hA5) & WM[i]);
				wr(8'hD2, 8'h80 | 8'(i), p == 0 ? 8'h5A : 8'hA5, 1'b1);
				chk8(q[i], e);
				rd(8'h80 | 8'(i), d);
				chk8(d, e);
			end
	endtask

	// Test controls writable, straps and identification read-only
	task automatic t_test_byte();
		logic [7:0] d;
		wr(8'hD2, 8'h86, 8'hFF, 1'b1);
		chk8(q[6], 8'hEA);
		wr(8'hD2, 8'h87, 8'h00, 1'b1);
		rd(8'h87, d);
		chk8(d, 8'h3C);
		rd(8'h86, d);
		chk8(d, 8'hEA);
		wr(8'hD2, 8'h86, 8'h00, 1'b1);
		chk8(q[6], 8'h0A);
	endtask

	// Foreign address and bad command codes are refused and change nothing
	task automatic t_refused();
		wr(8'hD4, 8'h80, 8'h00, 1'b0);
		wr(8'hD2, 8'h00, 8'h00, 1'b0);
		wr(8'hD2, 8'hA0, 8'h00, 1'b0);
		chk8(q[0], 8'hA5);
	endtask

	// Reset in mid-run brings every byte back to its default
	task automatic t_rereset();
		pgood_n <= 1'b1;
		i_resetn <= 1'b0;
		repeat (2) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		t_reset();
	endtask

	initial
	begin
		repeat (20) @(posedge i_sys_clk);
		i_resetn <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		t_reset();
		t_straps();
		t_write_all();
		t_test_byte();
		t_refused();
		t_rereset();
		give_verdict();
	end

	// Hang guard, far above the run's real length
	initial
	begin
		repeat (100000) @(posedge i_sys_clk);
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
